// *** hdl/rpd_pkg.sv ***
// constants, register map and carrier types for the reactive power datapath
// Contract
// RULE1: multiply voltage by 90 degree shifted current
// RULE2: low-pass product like the active power stage
// RULE3: scale by one plus gain over 4096
// RULE4: add signed 16-bit offset trim to result
// RULE5: 256 offset counts equal one waveform LSB
// RULE6: integrator on gives -90, off gives +90
// RULE7: reactive waveform samples at four selectable rates
// RULE8: sign change sets status one bit 4
// RULE9: direction bit clear: positive to negative only
// RULE10: direction bit set: negative to positive only
// RULE11: enabled sign flag keeps interrupt pending
// RULE12: below idle threshold suppresses energy accumulation
// RULE13: below idle threshold sets status one bit 1
// RULE14: enabled idle flag keeps interrupt pending
// RULE15: idle field: off, 0.015, 0.0075, 0.0037 percent
// RULE16: interrupt when any flag and enable set
package rpd_pkg;
  // data widths
  localparam int SMP_W = 24;                   // channel sample width
  localparam int PWR_W = 32;                   // filtered power width, 8 bits below wave lsb
  localparam int GAIN_W = 12;                  // gain trim width
  localparam int OFS_W = 16;                   // offset trim width
  localparam int GAIN_FRAC = 12;               // gain trim is divided by 2**12
  localparam int OFS_FRAC = 8;                 // 256 offset counts per wave lsb
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_WAVE_SEL = 8'h0d;  // waveform_select_reg
  localparam logic [7:0] IDX_IDLE_CFG = 8'h0e;  // idle_threshold_config
  localparam logic [7:0] IDX_ACC_CFG = 8'h0f;   // accumulation_config
  localparam logic [7:0] IDX_GAIN = 8'h1e;      // reactive_gain_trim
  localparam logic [7:0] IDX_OFS = 8'h21;       // reactive_offset_trim
  localparam logic [7:0] IDX_WAVE_DATA = 8'h40; // last waveform sample
  localparam logic [7:0] IDX_POWER = 8'h41;     // live reactive power
  localparam logic [7:0] IDX_IRQ_EN1 = 8'hd9;   // irq_enable_one
  localparam logic [7:0] IDX_IRQ_EN3 = 8'hdb;   // irq_enable_three
  localparam logic [7:0] IDX_IRQ_ST1 = 8'hdc;   // irq_status_one
  // field positions
  localparam int BIT_SIGN_FLAG = 4;            // reactive_polarity_change in status one
  localparam int BIT_IDLE_FLAG = 1;            // reactive_idle_flag in status one
  localparam int BIT_SIGN_DIR = 5;             // direction select in accumulation_config
  localparam int BIT_WAVE_IRQ = 5;             // waveform_sample_irq_enable
  localparam int IDLE_LSB = 2;                 // reactive_idle_level field [3:2]
  localparam int RATE_LSB = 2;                 // sample rate field [3:2] of wave select
  localparam logic [1:0] WAVE_SRC_REACTIVE = 2'h2; // source code for reactive power
  localparam logic [7:0] FLAG_MASK = 8'h12;     // implemented status one bits
  // idle thresholds in waveform lsb against full scale
  localparam longint FULL_SCALE = 64'h7fffff;
  localparam logic [23:0] IDLE_TH1 = 24'(FULL_SCALE * 15 / 100000);   // 0.015 %
  localparam logic [23:0] IDLE_TH2 = 24'(FULL_SCALE * 75 / 1000000);  // 0.0075 %
  localparam logic [23:0] IDLE_TH3 = 24'(FULL_SCALE * 37 / 1000000);  // 0.0037 %
  // waveform timing
  localparam longint CLK_HZ = 25000000;
  localparam longint WAVE_BASE_SPS = 25600;    // fastest rate, 25.6 kSPS
  localparam logic [15:0] WAVE_BASE_CYC = 16'(CLK_HZ / WAVE_BASE_SPS);
  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // channel sample pair carried together
  typedef struct packed {
    logic signed [SMP_W-1:0] volt;
    logic signed [SMP_W-1:0] curr;
  } rpd_sample_type;
endpackage

// *** hdl/rpd_core.sv ***
// reactive power datapath with axi4-lite registers, flags and waveform sampling
`timescale 1ns/1ps
module rpd_core #(
  parameter int ADDR_W = 12,   // axi address width
  parameter int LEAK_SH = 10,  // leak of the current integrator in shift steps
  parameter int LPF_SH = 8     // low-pass pole, same as the active power stage
) (
  // clock and reset
  input  wire logic                        CLK,
  input  wire logic                        SYS_RST,
  // channel samples from the adc filters, same clock
  input  wire rpd_pkg::rpd_sample_type     SAMPLE,
  input  wire logic                        SAMPLE_STB,
  input  wire logic                        INTEG_EN,
  // axi4-lite slave
  input  wire logic [ADDR_W-1:0]           S_AXI_AWADDR,
  input  wire logic                        S_AXI_AWVALID,
  output logic                             S_AXI_AWREADY,
  input  wire logic [31:0]                 S_AXI_WDATA,
  input  wire logic [3:0]                  S_AXI_WSTRB,
  input  wire logic                        S_AXI_WVALID,
  output logic                             S_AXI_WREADY,
  output logic [1:0]                       S_AXI_BRESP,
  output logic                             S_AXI_BVALID,
  input  wire logic                        S_AXI_BREADY,
  input  wire logic [ADDR_W-1:0]           S_AXI_ARADDR,
  input  wire logic                        S_AXI_ARVALID,
  output logic                             S_AXI_ARREADY,
  output logic [31:0]                      S_AXI_RDATA,
  output logic [1:0]                       S_AXI_RRESP,
  output logic                             S_AXI_RVALID,
  input  wire logic                        S_AXI_RREADY,
  // results
  output logic                             IRQ,
  output logic                             ACCUM_EN,
  output logic                             WAVE_VALID,
  output logic [23:0]                      WAVE_DATA
);
  import rpd_pkg::*;

  // elaboration check: word_idx needs bits 9:2, shifts must stay inside their words
  if (ADDR_W < 10 || LEAK_SH < 1 || LEAK_SH > 20 || LPF_SH < 1 || LPF_SH > 24) begin : g_bad_param
    $error("rpd_core: parameter out of range");
  end

  // word index from a byte address; unaligned low bits ignored
  function automatic logic [7:0] word_idx(input logic [ADDR_W-1:0] a);
    word_idx = a[9:2];
  endfunction

  // byte-lane merge of a write into an old value
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] st);
    merge = old;
    for (int b = 0; b < 4; b++) begin
      if (st[b]) begin
        merge[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
  endfunction

  // software registers
  logic [3:0]          wave_sel_q;     // [1:0] source, [3:2] rate
  logic [3:0]          idle_cfg_q;     // [3:2] idle level
  logic [7:0]          acc_cfg_q;      // bit 5 sign direction
  logic [GAIN_W-1:0]   gain_q;         // gain trim
  logic [OFS_W-1:0]    ofs_q;          // offset trim
  logic [7:0]          irq_en1_q;      // enables for status one
  logic [7:0]          irq_en3_q;      // bit 5 waveform sampling
  logic [7:0]          irq_st1_q;      // sticky flags
  // bus state
  logic                aw_full_q;      // write address held
  logic                w_full_q;       // write data held
  logic [7:0]          aw_idx_q;       // held write index
  logic [31:0]         wd_q;           // held write data
  logic [3:0]          ws_q;           // held write strobes
  logic                wr_do;          // write commit this cycle
  logic                rd_take;        // read address taken
  logic                st_read_clr;    // status one read this cycle
  // datapath
  logic signed [31:0]     integ_q;     // leaky current integrator
  logic signed [SMP_W-1:0] i_prev_q;   // previous current sample
  logic signed [SMP_W:0]   phase_q;    // shifted current
  logic signed [SMP_W-1:0] volt_q;     // voltage aligned with phase_q
  logic                   stb_q;       // phase stage valid
  logic                   stb2_q;      // lpf stage valid
  logic signed [PWR_W-1:0] lpf_q;      // filtered product
  logic signed [PWR_W-1:0] lpf_x;      // scaled product into the filter
  logic signed [PWR_W-1:0] pwr_sum;    // gained power plus offset
  logic signed [23:0]     pwr_q;       // power in waveform lsb
  logic                   upd_q;       // pwr_q refreshed
  logic                   neg_prev_q;  // sign of previous power
  logic                   idle;        // below idle threshold
  logic [23:0]            pwr_abs;     // magnitude of power
  logic [23:0]            idle_th;     // selected threshold
  logic                   sign_evt;    // qualified sign change
  // waveform sampler
  logic [18:0]            div_q;       // rate divider
  logic [18:0]            div_top;     // divider terminal count
  logic                   wave_on;     // reactive source and enable set

  // ---------------- axi write channel ----------------
  assign wr_do = aw_full_q && w_full_q && !S_AXI_BVALID;

  // address and data are accepted in either order and held until commit
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      S_AXI_AWREADY <= 1'b1;
      S_AXI_WREADY  <= 1'b1;
      aw_full_q     <= 1'b0;
      w_full_q      <= 1'b0;
      aw_idx_q      <= 8'h00;
      wd_q          <= 32'h0000_0000;
      ws_q          <= 4'h0;
      S_AXI_BVALID  <= 1'b0;
      S_AXI_BRESP   <= RESP_OKAY;
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_full_q     <= 1'b1;
        aw_idx_q      <= word_idx(S_AXI_AWADDR);
        S_AXI_AWREADY <= 1'b0;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_full_q     <= 1'b1;
        wd_q         <= S_AXI_WDATA;
        ws_q         <= S_AXI_WSTRB;
        S_AXI_WREADY <= 1'b0;
      end
      if (wr_do) begin
        aw_full_q    <= 1'b0;
        w_full_q     <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        // unmapped or read-only index answers with an error
        case (aw_idx_q)
          IDX_WAVE_SEL, IDX_IDLE_CFG, IDX_ACC_CFG, IDX_GAIN, IDX_OFS,
          IDX_IRQ_EN1, IDX_IRQ_EN3: S_AXI_BRESP <= RESP_OKAY;
          default: S_AXI_BRESP <= RESP_SLVERR;
        endcase
      end
      // both readies come back only once the response is taken
      if (S_AXI_BVALID && S_AXI_BREADY) begin
        S_AXI_BVALID  <= 1'b0;
        S_AXI_AWREADY <= 1'b1;
        S_AXI_WREADY  <= 1'b1;
      end
    end
  end

  // register writes, byte lanes honoured
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      wave_sel_q <= 4'h0;
      idle_cfg_q <= 4'h0;
      acc_cfg_q  <= 8'h00;
      gain_q     <= 12'h000;
      ofs_q      <= 16'h0000;
      irq_en1_q  <= 8'h00;
      irq_en3_q  <= 8'h00;
    end else if (wr_do) begin
      case (aw_idx_q)
        IDX_WAVE_SEL: wave_sel_q <= 4'(merge({28'h0, wave_sel_q}, wd_q, ws_q));
        IDX_IDLE_CFG: idle_cfg_q <= 4'(merge({28'h0, idle_cfg_q}, wd_q, ws_q));
        IDX_ACC_CFG:  acc_cfg_q  <= 8'(merge({24'h0, acc_cfg_q}, wd_q, ws_q));
        IDX_GAIN:     gain_q     <= 12'(merge({20'h0, gain_q}, wd_q, ws_q));
        IDX_OFS:      ofs_q      <= 16'(merge({16'h0, ofs_q}, wd_q, ws_q));
        IDX_IRQ_EN1:  irq_en1_q  <= 8'(merge({24'h0, irq_en1_q}, wd_q, ws_q));
        IDX_IRQ_EN3:  irq_en3_q  <= 8'(merge({24'h0, irq_en3_q}, wd_q, ws_q));
        default: ;  // read-only or unmapped, nothing stored
      endcase
    end
  end

  // ---------------- axi read channel ----------------
  assign rd_take = S_AXI_ARVALID && S_AXI_ARREADY;
  assign st_read_clr = rd_take && (word_idx(S_AXI_ARADDR) == IDX_IRQ_ST1);

  // one read at a time, answered the cycle after the address is taken
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      S_AXI_ARREADY <= 1'b1;
      S_AXI_RVALID  <= 1'b0;
      S_AXI_RDATA   <= 32'h0000_0000;
      S_AXI_RRESP   <= RESP_OKAY;
    end else begin
      if (rd_take) begin
        S_AXI_ARREADY <= 1'b0;
        S_AXI_RVALID  <= 1'b1;
        S_AXI_RRESP   <= RESP_OKAY;
        case (word_idx(S_AXI_ARADDR))
          IDX_WAVE_SEL:  S_AXI_RDATA <= {28'h0, wave_sel_q};
          IDX_IDLE_CFG:  S_AXI_RDATA <= {28'h0, idle_cfg_q};
          IDX_ACC_CFG:   S_AXI_RDATA <= {24'h0, acc_cfg_q};
          IDX_GAIN:      S_AXI_RDATA <= {20'h0, gain_q};
          IDX_OFS:       S_AXI_RDATA <= {16'h0, ofs_q};
          IDX_WAVE_DATA: S_AXI_RDATA <= {8'h0, WAVE_DATA};
          IDX_POWER:     S_AXI_RDATA <= {8'h0, pwr_q};
          IDX_IRQ_EN1:   S_AXI_RDATA <= {24'h0, irq_en1_q};
          IDX_IRQ_EN3:   S_AXI_RDATA <= {24'h0, irq_en3_q};
          IDX_IRQ_ST1:   S_AXI_RDATA <= {24'h0, irq_st1_q};
          default: begin
            S_AXI_RDATA <= 32'h0000_0000;
            S_AXI_RRESP <= RESP_SLVERR;
          end
        endcase
      end else if (S_AXI_RVALID && S_AXI_RREADY) begin
        S_AXI_RVALID  <= 1'b0;
        S_AXI_ARREADY <= 1'b1;
      end
    end
  end

  // ---------------- phase shift stage ----------------
  // integrator gives -90 degrees, first difference +90; the leak keeps the
  // integrator from running away on a dc offset at the cost of a small phase error
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      integ_q  <= 32'h0000_0000;
      i_prev_q <= 24'h00_0000;
      phase_q  <= 25'h000_0000;
      volt_q   <= 24'h00_0000;
      stb_q    <= 1'b0;
    end else begin
      stb_q <= SAMPLE_STB;
      if (SAMPLE_STB) begin
        integ_q  <= integ_q - (integ_q >>> LEAK_SH) + 32'(SAMPLE.curr);
        i_prev_q <= SAMPLE.curr;
        volt_q   <= SAMPLE.volt;
        if (INTEG_EN) begin
          phase_q <= 25'(integ_q >>> LEAK_SH);  // [RULE6]
        end else begin
          phase_q <= 25'(SAMPLE.curr) - 25'(i_prev_q);  // [RULE6]
        end
      end
    end
  end

  // ---------------- product and low-pass ----------------
  assign lpf_x = 32'((49'(volt_q) * 49'(phase_q)) >>> 17);  // [RULE1]

  // first-order pole shared in form with the active power filter
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      lpf_q  <= 32'h0000_0000;
      stb2_q <= 1'b0;
    end else begin
      stb2_q <= stb_q;
      if (stb_q) begin
        lpf_q <= lpf_q + ((lpf_x - lpf_q) >>> LPF_SH);  // [RULE2]
      end
    end
  end

  // ---------------- gain and offset ----------------
  // offset sits 8 bits below the waveform lsb, so 0x100 moves one lsb
  assign pwr_sum = 32'((48'(lpf_q) * (48'(signed'(gain_q)) + 48'sh1000)) >>> GAIN_FRAC)  // [RULE3]
                 + 32'(signed'(ofs_q));  // [RULE4]

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      pwr_q <= 24'h00_0000;
      upd_q <= 1'b0;
    end else begin
      upd_q <= stb2_q;
      if (stb2_q) begin
        pwr_q <= pwr_sum[PWR_W-1:OFS_FRAC];  // [RULE5]
      end
    end
  end

  // ---------------- idle and sign detection ----------------
  assign pwr_abs = pwr_q[23] ? 24'(-pwr_q) : pwr_q;
  always_comb begin
    case (idle_cfg_q[IDLE_LSB +: 2])  // [RULE15]
      2'h1: idle_th = IDLE_TH1;
      2'h2: idle_th = IDLE_TH2;
      2'h3: idle_th = IDLE_TH3;
      default: idle_th = 24'h00_0000;  // detection off, nothing is below zero
    endcase
  end
  assign idle = pwr_abs < idle_th;
  assign sign_evt = upd_q && (acc_cfg_q[BIT_SIGN_DIR]
                    ? (neg_prev_q && !pwr_q[23])    // [RULE10]
                    : (!neg_prev_q && pwr_q[23]));  // [RULE9]

  // remembered sign follows each fresh power value
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      neg_prev_q <= 1'b0;
      ACCUM_EN   <= 1'b1;
    end else begin
      if (upd_q) begin
        neg_prev_q <= pwr_q[23];
      end
      ACCUM_EN <= !idle;  // [RULE12]
    end
  end

  // sticky flags; a set in the cycle of the clearing read wins
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      irq_st1_q <= 8'h00;
    end else begin
      irq_st1_q <= (st_read_clr ? 8'h00 : irq_st1_q)
                 | ({7'h0, sign_evt} << BIT_SIGN_FLAG)  // [RULE8]
                 | ({7'h0, idle} << BIT_IDLE_FLAG);     // [RULE13]
    end
  end

  // one level interrupt from enabled flags
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= |(irq_st1_q & irq_en1_q & FLAG_MASK);  // [RULE11] [RULE14] [RULE16]
    end
  end

  // ---------------- waveform sampler ----------------
  assign wave_on = (wave_sel_q[1:0] == WAVE_SRC_REACTIVE) && irq_en3_q[BIT_WAVE_IRQ];
  assign div_top = 19'((19'(WAVE_BASE_CYC) << wave_sel_q[RATE_LSB +: 2]) - 19'h1);

  // rates 25.6, 12.8, 6.4, 3.2 kSPS by doubling the base period
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      div_q      <= 19'h0_0000;
      WAVE_VALID <= 1'b0;
      WAVE_DATA  <= 24'h00_0000;
    end else begin
      WAVE_VALID <= 1'b0;
      if (!wave_on || div_q >= div_top) begin
        div_q <= 19'h0_0000;
      end else begin
        div_q <= div_q + 19'h1;
      end
      if (wave_on && div_q >= div_top) begin
        WAVE_VALID <= 1'b1;  // [RULE7]
        WAVE_DATA  <= pwr_q;
      end
    end
  end

  // ---------------- assertions ----------------
  a_sign_fall: assert property (@(posedge CLK) disable iff (SYS_RST)  // [RULE9]
    upd_q && !acc_cfg_q[BIT_SIGN_DIR] && !neg_prev_q && pwr_q[23]
    |=> irq_st1_q[BIT_SIGN_FLAG]) else $error("missed falling sign change");
  a_sign_rise: assert property (@(posedge CLK) disable iff (SYS_RST)  // [RULE10]
    upd_q && acc_cfg_q[BIT_SIGN_DIR] && neg_prev_q && !pwr_q[23]
    |=> irq_st1_q[BIT_SIGN_FLAG]) else $error("missed rising sign change");
  a_sign_quiet: assert property (@(posedge CLK) disable iff (SYS_RST)  // [RULE8]
    !irq_st1_q[BIT_SIGN_FLAG] && !(upd_q && neg_prev_q != pwr_q[23])
    |=> !irq_st1_q[BIT_SIGN_FLAG]) else $error("sign flag set without a change");
  a_idle_flag: assert property (@(posedge CLK) disable iff (SYS_RST)  // [RULE13]
    idle |=> irq_st1_q[BIT_IDLE_FLAG] && !ACCUM_EN) else $error("idle not flagged");
  a_idle_off: assert property (@(posedge CLK) disable iff (SYS_RST)  // [RULE15]
    idle_cfg_q[IDLE_LSB +: 2] == 2'h0 |=> ACCUM_EN) else $error("idle with detection off");
  a_irq_level: assert property (@(posedge CLK) disable iff (SYS_RST)  // [RULE16]
    ##1 IRQ == $past(|(irq_st1_q & irq_en1_q & FLAG_MASK))) else $error("irq level wrong");
  a_irq_hold: assert property (@(posedge CLK) disable iff (SYS_RST)  // [RULE11]
    irq_st1_q[BIT_SIGN_FLAG] && irq_en1_q[BIT_SIGN_FLAG] && !st_read_clr
    |=> IRQ [*2]) else $error("irq dropped while flag pending");
  a_offset_lsb: assert property (@(posedge CLK) disable iff (SYS_RST)  // [RULE5]
    stb2_q && gain_q == 12'h000 && ofs_q == 16'h0100
    |=> pwr_q == 24'($past(pwr_sum) >>> OFS_FRAC)
        && pwr_q == 24'(($past(lpf_q) + 32'sh100) >>> OFS_FRAC)) else $error("offset weight");
  a_diff_phase: assert property (@(posedge CLK) disable iff (SYS_RST)  // [RULE6]
    SAMPLE_STB && !INTEG_EN
    |=> phase_q == 25'($past(SAMPLE.curr)) - 25'($past(i_prev_q))) else $error("phase path");
  a_wave_gate: assert property (@(posedge CLK) disable iff (SYS_RST)  // [RULE7]
    WAVE_VALID |-> $past(wave_on) && !$past(WAVE_VALID)) else $error("wave without enable");

  c_sign_event: cover property (@(posedge CLK) disable iff (SYS_RST) sign_evt);
  c_idle_irq: cover property (@(posedge CLK) disable iff (SYS_RST)
    irq_st1_q[BIT_IDLE_FLAG] && IRQ);
  c_wave_sample: cover property (@(posedge CLK) disable iff (SYS_RST) WAVE_VALID);
endmodule

// *** sim/rpd_src_model.sv ***
// sample source standing in for the adc filter outputs
`timescale 1ns/1ps
module rpd_src_model (
  // levels chosen by the bench
  input  wire logic signed [23:0] VOLT,
  input  wire logic signed [23:0] CURR,
  // sample stream into the datapath
  output rpd_pkg::rpd_sample_type SAMPLE,
  output logic                    SAMPLE_STB
);
  // strobe every cycle: back to back pairs let the filters settle fastest
  assign SAMPLE_STB = 1'b1;
  // pair travels together, voltage in the upper half
  assign SAMPLE = {VOLT, CURR};
endmodule

// *** sim/rpd_core_bench.sv ***
// self-checking bench for the reactive power datapath
`timescale 1ns/1ps
module rpd_core_bench;
  import rpd_pkg::*;
  // clock, reset and sample levels
  logic               clk, rst, integ;
  logic signed [23:0] volt, curr;
  rpd_sample_type     smp;
  logic               stb;
  // bus master side
  logic [11:0]        awaddr, araddr;
  logic               awvalid, wvalid, bready, arvalid, rready;
  logic [31:0]        wdata, rdata, d, p0;
  logic [1:0]         bresp, rresp, resp;
  logic               awready, wready, bvalid, arready, rvalid;
  // results
  logic               irq, acc_en, wvld;
  logic [23:0]        wave;
  int                 err_count, n_checks, cyc;
  logic [7:0]         rw [8];

  rpd_src_model rpd_src_model_i (.VOLT(volt), .CURR(curr), .SAMPLE(smp), .SAMPLE_STB(stb));
  rpd_core rpd_core_i (
    .CLK(clk), .SYS_RST(rst), .SAMPLE(smp), .SAMPLE_STB(stb), .INTEG_EN(integ),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .IRQ(irq), .ACCUM_EN(acc_en), .WAVE_VALID(wvld), .WAVE_DATA(wave));

  // 25 mhz clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // verdict, reached from the tests and the watchdog alike
  task automatic conclude();
    if (err_count == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // one counted compare
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  // axi write: address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] i, input logic [31:0] v);
    @(posedge clk);
    awaddr <= {2'h0, i, 2'h0};
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    resp = bresp;
    bready <= 1'b0;
  endtask

  // axi read into d and resp
  task automatic rd(input logic [7:0] i);
    @(posedge clk);
    araddr <= {2'h0, i, 2'h0};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask

  // watchdog, beyond the roughly 80k cycles the tests need
  initial begin
    repeat (90000) @(posedge clk);
    err_count++;
    conclude();
  end

  // test sequence
  initial begin
    {rst, integ} = 2'b11;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, volt, curr} = '0;
    rw = '{IDX_WAVE_SEL, IDX_IDLE_CFG, IDX_ACC_CFG, IDX_GAIN, IDX_OFS,
           IDX_IRQ_EN1, IDX_IRQ_EN3, IDX_IRQ_ST1};
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    // every register resets to zero
    foreach (rw[k]) begin
      rd(rw[k]);
      chk("reset value", 32'h0, d);
    end
    wr(IDX_GAIN, 32'hffffffff);
    chk("write resp", 32'(RESP_OKAY), 32'(resp));
    rd(IDX_GAIN);
    chk("gain width", 32'h00000fff, d);
    chk("read resp", 32'(RESP_OKAY), 32'(resp));
    wr(IDX_OFS, 32'hffffffff);
    rd(IDX_OFS);
    chk("offset width", 32'h0000ffff, d);
    wr(IDX_OFS, 32'h0);
    wr(IDX_GAIN, 32'h0);
    rd(8'h01);
    chk("unmapped read", 32'(RESP_SLVERR), 32'(resp));
    wr(IDX_POWER, 32'h1);
    chk("read-only write", 32'(RESP_SLVERR), 32'(resp));
    // the all-ones offset pushed the zero power negative for a few cycles
    rd(IDX_IRQ_ST1);
    chk("trim sign flag", 32'h10, d);
    // positive load through the integrating shifter; levels big enough that
    // the product clears the truncation dead band of the filter
    volt <= 24'sh40_0000;
    curr <= 24'sh00_0400;
    repeat (12000) @(posedge clk);
    wr(IDX_IRQ_EN1, 32'h10);
    rd(IDX_IRQ_ST1);
    chk("no spurious sign", 32'h0, d);
    rd(IDX_POWER);
    p0 = d;
    chk("positive sign", 32'h0, 32'(p0[23]));
    chk("power nonzero", 32'h1, 32'(p0[23:0] != 24'h0));
    wr(IDX_GAIN, 32'h800);
    repeat (10) @(posedge clk);
    rd(IDX_POWER);
    chk("half gain", 32'(24'($signed(p0[23:0]) >>> 1)), 32'(d[23:0]));
    wr(IDX_OFS, 32'h100);
    repeat (10) @(posedge clk);
    rd(IDX_POWER);
    chk("offset lsb", 32'(24'($signed(p0[23:0]) >>> 1) + 24'h1), 32'(d[23:0]));
    wr(IDX_GAIN, 32'h0);
    repeat (10) @(posedge clk);
    rd(IDX_POWER);
    chk("offset unity gain", p0 + 32'h1, d);
    wr(IDX_OFS, 32'h0);
    // positive to negative with default direction
    volt <= -24'sh40_0000;
    repeat (4000) @(posedge clk);
    chk("sign irq", 32'h1, 32'(irq));
    rd(IDX_POWER);
    chk("negative sign", 32'h1, 32'(d[23]));
    rd(IDX_IRQ_ST1);
    chk("sign flag", 32'h10, d);
    rd(IDX_IRQ_ST1);
    chk("clear on read", 32'h0, d);
    repeat (3) @(posedge clk);
    chk("irq released", 32'h0, 32'(irq));
    volt <= 24'sh40_0000;
    repeat (4000) @(posedge clk);
    rd(IDX_IRQ_ST1);
    chk("rise ignored", 32'h0, d);
    // opposite direction selected
    wr(IDX_ACC_CFG, 32'h20);
    volt <= -24'sh40_0000;
    repeat (4000) @(posedge clk);
    rd(IDX_IRQ_ST1);
    chk("fall ignored", 32'h0, d);
    volt <= 24'sh40_0000;
    repeat (4000) @(posedge clk);
    rd(IDX_IRQ_ST1);
    chk("rise flag", 32'h10, d);
    wr(IDX_ACC_CFG, 32'h0);
    // waveform pacing at each rate
    wr(IDX_IRQ_EN3, 32'h20);
    for (int r = 0; r < 4; r++) begin
      wr(IDX_WAVE_SEL, 32'(r * 4 + 2));
      repeat (2) do @(posedge clk); while (!wvld);
      cyc = 0;
      do begin
        @(posedge clk);
        cyc++;
      end while (!wvld);
      chk("wave period", 32'(WAVE_BASE_CYC) << r, 32'(cyc));
    end
    rd(IDX_POWER);
    chk("wave sample", 32'(d[23:0]), 32'(wave));
    // no load, detection off then each threshold
    wr(IDX_IRQ_EN1, 32'h02);
    volt <= 24'sd0;
    repeat (4000) @(posedge clk);
    chk("idle off", 32'h1, 32'(acc_en));
    for (int c = 1; c < 4; c++) begin
      wr(IDX_IDLE_CFG, 32'(c * 4));
      repeat (8) @(posedge clk);
      chk("accum held", 32'h0, 32'(acc_en));
      chk("idle irq", 32'h1, 32'(irq));
      rd(IDX_IRQ_ST1);
      chk("idle flag", 32'h02, d);
    end
    wr(IDX_IRQ_EN1, 32'h0);
    repeat (3) @(posedge clk);
    chk("masked irq", 32'h0, 32'(irq));
    // differencing shifter: falling current ramp against a positive voltage
    integ <= 1'b0;
    volt <= 24'sh40_0000;
    repeat (2000) begin
      @(posedge clk);
      curr <= curr - 24'sh00_0040;
    end
    rd(IDX_POWER);
    chk("difference path", 32'h00fffff8, 32'(d[23:0]));
    conclude();
  end
endmodule
